// File: compare_timer_map.svh
// Purpose: register offsets, field positions, reset values and divider masks
// Assumes: byte-wide register port, offsets as printed for the timer
// Notes:   definitions only
`ifndef COMPARE_TIMER_MAP_SVH
`define COMPARE_TIMER_MAP_SVH

// register offsets
`define OFS_CTRL_PRI    8'h14
`define OFS_CTRL_SEC    8'h15
`define OFS_CMP_LOW     8'h16
`define OFS_CMP_HIGH    8'h17
`define OFS_STATUS      8'h18

// primary control fields
`define PRI_START       0
`define PRI_SRC_SEL     1
`define PRI_BOTH_EDGE   2
`define PRI_POLARITY    3
`define PRI_ONE_SHOT    4
`define PRI_PULSE_MODE  5
`define PRI_START_PHASE 6
`define PRI_SOFT_RESET  7

// secondary control fields
`define SEC_FLOP_INIT   0
`define SEC_CLK_LO      1
`define SEC_CLK_HI      3
`define SEC_REGS_LO     4
`define SEC_REGS_HI     5
`define SEC_TRIG_DIS    6

// reset values and read masks
`define PRI_RESET       8'h00
`define SEC_RESET       8'h00
`define PRI_READ_MASK   8'h7F
`define SEC_READ_MASK   8'h7F

// clock source and register count codes
`define CLK_EXT_PIN     3'h7
`define REGS_AB         2'h1
`define REGS_ABC        2'h2

// prescaler masks: tick when the low bits are all ones (period 2^n)
`define PRE_MASK_C0     12'h7FF
`define PRE_MASK_C1     12'h07F
`define PRE_MASK_C2     12'h01F
`define PRE_MASK_C3     12'h007
`define PRE_MASK_C4     12'h003
`define PRE_MASK_C5     12'h001

`endif

// File: compare_timer_pkg.sv
// Purpose: state types of the compare timer control block
// Assumes: nothing beyond the map header
// Notes:   one-hot run states
package compare_timer_pkg;

  // run state of the counter
  typedef enum logic [1:0] {
    RUN_IDLE  = 2'b01,
    RUN_COUNT = 2'b10
  } run_state_t;

  // full state of the control block
  typedef struct packed {
    logic [7:0]  ctrlPri;
    logic [7:0]  ctrlSec;
    logic [7:0]  lowHold;
    logic [15:0] cmpA;
    logic [15:0] cmpB;
    logic [15:0] cmpC;
    logic [1:0]  wrPtr;
    logic [15:0] count;
    run_state_t  run;
    logic        flop;
    logic        irq;
    logic [7:0]  rdData;
    logic [2:0]  pinSync;
  } ctc_state_t;

  // state of the prescaler
  typedef struct packed {
    logic [11:0] div;
  } pre_state_t;

endpackage

// File: prescaler_tick.sv
// Purpose: divides the core clock into the selected count tick
// Assumes: clear comes from logic on the same clock
// Notes:   codes 110 and 111 give no internal tick
`timescale 1ns/1ps
`include "compare_timer_map.svh"

module prescaler_tick import compare_timer_pkg::*; (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       nrst,
  // control
  input  wire logic       clear,
  input  wire logic [2:0] clkSel,
  input  wire logic       divOption,
  // tick
  output logic            tick
);

  pre_state_t  s_reg;      // registered state
  pre_state_t  s_next;     // next state
  logic [11:0] baseMask;   // mask for the plain divider
  logic [11:0] mask;       // mask with the divide option applied
  logic        valid;      // code selects an internal clock

  always_comb begin
    valid    = 1'b1;
    baseMask = 12'h000;
    unique case (clkSel)
      3'h0: baseMask = `PRE_MASK_C0;
      3'h1: baseMask = `PRE_MASK_C1;
      3'h2: baseMask = `PRE_MASK_C2;
      3'h3: baseMask = `PRE_MASK_C3;
      3'h4: baseMask = `PRE_MASK_C4;
      3'h5: baseMask = `PRE_MASK_C5;
      default: valid = 1'b0;
    endcase
    // the option doubles every period
    mask = divOption ? {baseMask[10:0], 1'b1} : baseMask;
    tick = valid & ((s_reg.div & mask) == mask);
  end

  // free-running divider, cleared by soft reset
  always_comb begin
    s_next     = s_reg;
    s_next.div = clear ? 12'h000 : s_reg.div + 12'h001;
  end

  // state register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule

// File: compare_timer_control.sv
// Purpose: control and timer part of a 16-bit compare timer/counter
// Assumes: byte register port with read data one cycle after the strobe
// Notes:   trigger pin is asynchronous and passes a two-flop synchroniser
`timescale 1ns/1ps
`include "compare_timer_map.svh"

// Function
// - compare registers write-only, read zero
// - soft-reset bit always reads zero
// - compare words fill A, then B, then C
// - start cleared stops and clears counter
// - source select: software or pin trigger
// - both-edge bit: opposite edge also stops counter
// - polarity picks start and count edge
// - one-shot match raises interrupt and stops
// - mode bit: timer/event or pulse generator
// - soft reset clears all but compare values, keeps interrupt
// - flop init bit sets output level while stopped
// - clock source code selects divider or pin
// - register count selects A, AB, ABC
// - B and C writes gated by mode, count
// - trigger disable forces trigger input low
// - timer match interrupts, clears, keeps counting
// - active pin edge resets counter while enabled, except with clock source code 111
// - opposite edge clears and stops counter
module compare_timer_control import compare_timer_pkg::*; (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       nrst,
  // register port
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic [7:0]      regRdData,
  // system prescaler option
  input  wire logic       divOption,
  // shared trigger pin
  input  wire logic       triggerPin,
  // outputs
  output logic            compareMatchIrq,
  output logic            pulseOut
);

  ctc_state_t  s_reg;       // registered state
  ctc_state_t  s_next;      // next state
  logic        preTick;     // internal clock tick
  logic        startCtl;    // start control bit
  logic        extStart;    // start from pin trigger
  logic        bothEdges;   // both edges enabled
  logic        polFall;     // falling edge active
  logic        oneShot;     // one-shot cycle
  logic        pulseMode;   // pulse generator operation
  logic        trigDis;     // pin trigger disabled
  logic [2:0]  clkSel;      // clock source code
  logic [1:0]  regCount;    // register count code
  logic        trigNow;     // gated trigger, current
  logic        trigOld;     // gated trigger, previous
  logic        rise;        // rising edge seen
  logic        fall;        // falling edge seen
  logic        actEdge;     // active edge seen
  logic        oppEdge;     // opposite edge seen
  logic        tick;        // count tick
  logic [15:0] cmpEnd;      // compare value closing the cycle
  logic        matchEnd;    // counter at the closing value on a tick
  logic        softRst;     // soft reset written this cycle
  logic [1:0]  lastPtr;     // last register in the write sequence
  logic        ptrOk;       // current write target is enabled

  // control field decode
  assign startCtl  = s_reg.ctrlPri[`PRI_START];
  assign extStart  = s_reg.ctrlPri[`PRI_SRC_SEL];
  assign bothEdges = s_reg.ctrlPri[`PRI_BOTH_EDGE];
  assign polFall   = s_reg.ctrlPri[`PRI_POLARITY];
  assign oneShot   = s_reg.ctrlPri[`PRI_ONE_SHOT];
  assign pulseMode = s_reg.ctrlPri[`PRI_PULSE_MODE];
  assign trigDis   = s_reg.ctrlSec[`SEC_TRIG_DIS];
  assign clkSel    = s_reg.ctrlSec[`SEC_CLK_HI:`SEC_CLK_LO];
  assign regCount  = s_reg.ctrlSec[`SEC_REGS_HI:`SEC_REGS_LO];

  // only the second and third stages are read; the first may still be settling
  // disabled trigger reads as a constant zero
  assign trigNow = s_reg.pinSync[1] & ~trigDis;
  assign trigOld = s_reg.pinSync[2] & ~trigDis;
  assign rise    = trigNow & ~trigOld;
  assign fall    = ~trigNow & trigOld;

  assign actEdge = polFall ? fall : rise;
  assign oppEdge = polFall ? rise : fall;

  // code 111 counts pin edges instead of the prescaler
  assign tick = (clkSel == `CLK_EXT_PIN) ? actEdge : preTick;

  // the last selected register closes a pulse cycle
  always_comb begin
    cmpEnd  = s_reg.cmpA;
    lastPtr = 2'h0;
    if (pulseMode && regCount == `REGS_AB) begin
      cmpEnd  = s_reg.cmpB;
      lastPtr = 2'h1;
    end else if (pulseMode && regCount == `REGS_ABC) begin
      cmpEnd  = s_reg.cmpC;
      lastPtr = 2'h2;
    end
  end

  // a match counts only on a tick, so a stalled divider never closes a cycle
  assign matchEnd = tick && (s_reg.count == cmpEnd);
  assign softRst  = regWr && regAddr == `OFS_CTRL_PRI && regWrData[`PRI_SOFT_RESET];

  // a refused word also sends the pointer back to A, so software can always recover
  // B and C only in pulse mode and only when counted
  assign ptrOk = (s_reg.wrPtr == 2'h0) || (pulseMode && s_reg.wrPtr <= lastPtr);

  // prescaler, cleared with the soft reset
  // clearing it keeps the first tick after a soft reset a whole period away
  prescaler_tick u_pre (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .clear     (softRst),
    .clkSel    (clkSel),
    .divOption (divOption),
    .tick      (preTick)
  );

  // next-state logic: synchroniser, reads, counter, writes
  always_comb begin
    s_next         = s_reg;
    s_next.irq     = 1'b0;
    s_next.rdData  = 8'h00;
    s_next.pinSync = {s_reg.pinSync[1:0], triggerPin};

    // register reads; compare bytes have no read path
    if (regRd) begin
      unique case (regAddr)
        `OFS_CTRL_PRI: s_next.rdData = s_reg.ctrlPri & `PRI_READ_MASK;
        `OFS_CTRL_SEC: s_next.rdData = s_reg.ctrlSec & `SEC_READ_MASK;
        `OFS_STATUS:   s_next.rdData = {6'h00, s_reg.flop, s_reg.run == RUN_COUNT};
        default:       s_next.rdData = 8'h00;
      endcase
    end

    // counter state machine
    unique case (s_reg.run)
      RUN_IDLE: begin
        s_next.count = 16'h0000;
        // software start, or wait for the active pin edge
        if (startCtl && (!extStart || actEdge)) begin
          s_next.run = RUN_COUNT;
          // pulse output may invert right at start
          if (pulseMode && s_reg.ctrlPri[`PRI_START_PHASE]) begin
            s_next.flop = ~s_reg.flop;
          end
        end
      end
      RUN_COUNT: begin
        if (!startCtl) begin
          s_next.run   = RUN_IDLE;
          s_next.count = 16'h0000;
        end else if (extStart && bothEdges && oppEdge) begin
          // opposite edge only when both are enabled
          s_next.run   = RUN_IDLE;
          s_next.count = 16'h0000;
        end else if (actEdge && clkSel != `CLK_EXT_PIN) begin
          // a live pin edge resets the count
          s_next.count = 16'h0000;
        end else if (matchEnd) begin
          s_next.irq   = 1'b1;
          s_next.count = 16'h0000;
          // pulse mode toggles on the closing match, except in one-shot
          if (pulseMode && !oneShot) begin
            s_next.flop = ~s_reg.flop;
          end
          // one-shot stops until the next start
          if (oneShot) begin
            s_next.run = RUN_IDLE;
            if (!extStart) begin
              s_next.ctrlPri[`PRI_START] = 1'b0;
            end
          end
        end else if (tick) begin
          s_next.count = s_reg.count + 16'h0001;
          if (pulseMode && ((s_reg.count == s_reg.cmpA && lastPtr != 2'h0) ||
                            (s_reg.count == s_reg.cmpB && lastPtr == 2'h2))) begin
            s_next.flop = ~s_reg.flop;
          end
        end
      end
      default: begin
        // illegal code falls back to stopped
        s_next.run   = RUN_IDLE;
        s_next.count = 16'h0000;
      end
    endcase

    // register writes
    if (regWr) begin
      unique case (regAddr)
        `OFS_CTRL_PRI: begin
          // the soft-reset bit is never stored
          s_next.ctrlPri = regWrData & `PRI_READ_MASK;
        end
        `OFS_CTRL_SEC: begin
          s_next.ctrlSec = regWrData & `SEC_READ_MASK;
          // load the output flop while stopped
          if (s_reg.run == RUN_IDLE) begin
            s_next.flop = regWrData[`SEC_FLOP_INIT];
          end
        end
        `OFS_CMP_LOW: begin
          s_next.lowHold = regWrData;
        end
        `OFS_CMP_HIGH: begin
          // commit in sequence A, B, C
          if (ptrOk) begin
            unique case (s_reg.wrPtr)
              2'h0:    s_next.cmpA = {regWrData, s_reg.lowHold};
              2'h1:    s_next.cmpB = {regWrData, s_reg.lowHold};
              default: s_next.cmpC = {regWrData, s_reg.lowHold};
            endcase
            s_next.wrPtr = (s_reg.wrPtr >= lastPtr) ? 2'h0 : s_reg.wrPtr + 2'h1;
          end else begin
            s_next.wrPtr = 2'h0;
          end
        end
        default: begin
          // unmapped write has no effect
          s_next.lowHold = s_reg.lowHold;
        end
      endcase
    end

    // soft reset wins over all, interrupt pulse survives
    if (softRst) begin
      s_next.ctrlPri = `PRI_RESET;
      s_next.ctrlSec = `SEC_RESET;
      s_next.lowHold = 8'h00;
      s_next.wrPtr   = 2'h0;
      s_next.count   = 16'h0000;
      s_next.run     = RUN_IDLE;
      s_next.flop    = 1'b0;
    end
  end

  // state register; compare values start at zero
  // only nrst clears the compare values, a soft reset keeps them for the next run
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_reg         <= '0;
      s_reg.ctrlPri <= `PRI_RESET;
      s_reg.ctrlSec <= `SEC_RESET;
      s_reg.run     <= RUN_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state flops
  assign regRdData       = s_reg.rdData;
  assign compareMatchIrq = s_reg.irq;
  assign pulseOut        = s_reg.flop;

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // these watch internal state as well as pins, so a broken branch of the counter
  // shows up here long before the bench can measure a wrong period

  a_reset_bit_reads: assert property (
    regRd && regAddr == `OFS_CTRL_PRI |=> regRdData[`PRI_SOFT_RESET] == 1'b0)
    else $error("soft reset bit read back as one");

  a_wo_reads_zero: assert property (
    regRd && (regAddr == `OFS_CMP_LOW || regAddr == `OFS_CMP_HIGH) |=> regRdData == 8'h00)
    else $error("compare register returned data");

  a_low_byte_held: assert property (
    regWr && regAddr == `OFS_CMP_LOW && !softRst
      |=> s_reg.cmpA == $past(s_reg.cmpA) && s_reg.lowHold == $past(regWrData))
    else $error("low byte changed a compare value");

  a_gate_b_write: assert property (
    regWr && regAddr == `OFS_CMP_HIGH && s_reg.wrPtr == 2'h1 && !pulseMode
      |=> $stable(s_reg.cmpB) && s_reg.wrPtr == 2'h0)
    else $error("register B written outside pulse mode");

  a_stop_clears: assert property (
    !startCtl |=> s_reg.count == 16'h0000 && s_reg.run == RUN_IDLE)
    else $error("counter ran without start");

  a_ext_waits: assert property (
    s_reg.run == RUN_IDLE && extStart && !actEdge && !softRst |=> s_reg.run == RUN_IDLE)
    else $error("trigger start began without an edge");

  a_trig_disable: assert property (
    trigDis && s_reg.pinSync[1] != s_reg.pinSync[2] && s_reg.run == RUN_IDLE
      && startCtl && extStart && !softRst |=> s_reg.run == RUN_IDLE)
    else $error("disabled trigger started the counter");

  a_match_irq: assert property (
    s_reg.run == RUN_COUNT && startCtl && matchEnd && !actEdge && !oppEdge && !softRst
      |=> compareMatchIrq && s_reg.count == 16'h0000)
    else $error("match did not interrupt and clear");

  a_oneshot_stop: assert property (
    s_reg.run == RUN_COUNT && startCtl && oneShot && matchEnd && !actEdge && !oppEdge && !softRst
      |=> s_reg.run == RUN_IDLE ##1 s_reg.count == 16'h0000)
    else $error("one-shot kept running");

  a_soft_reset: assert property (
    softRst |=> pulseOut == 1'b0 && s_reg.count == 16'h0000 && s_reg.ctrlSec == `SEC_RESET)
    else $error("soft reset left state behind");

  a_opposite_stop: assert property (
    s_reg.run == RUN_COUNT && startCtl && extStart && bothEdges && oppEdge && !softRst
      |=> s_reg.run == RUN_IDLE && s_reg.count == 16'h0000)
    else $error("opposite edge did not stop counter");

  a_flop_init: assert property (
    regWr && regAddr == `OFS_CTRL_SEC && s_reg.run == RUN_IDLE
      |=> pulseOut == $past(regWrData[`SEC_FLOP_INIT]))
    else $error("output flop not loaded from the init bit");

  a_pin_clears: assert property (
    s_reg.run == RUN_COUNT && startCtl && actEdge && clkSel != `CLK_EXT_PIN && !softRst
      |=> s_reg.count == 16'h0000)
    else $error("live pin edge did not clear the counter");

endmodule

// File: trigger_pin_source.sv
// Purpose: drives the shared trigger pin from outside the block
// Assumes: the pin is a plain level input with no pull resistor
// Notes:   edges land mid-cycle, 30 ns after a rising edge of the core clock
`timescale 1ns/1ps

module trigger_pin_source (
  // clock used only to space the edges
  input  wire logic core_clk,
  // pin level seen by the block
  output logic      triggerPin
);
  // pin starts low so the first rising edge is a clean one
  initial triggerPin = 1'b0;

  // edges of either polarity
  // the level changes well clear of the clock edge; the block synchronises it
  task automatic set_level(input logic lvl);
    @(posedge core_clk);
    #30 triggerPin = lvl;
  endtask
endmodule

// File: test_compare_timer_control.sv
// Purpose: self-checking bench for the compare timer control block
// Assumes: byte register port, read data in the cycle after the strobe
// Notes:   one task per scenario; periods come from the divider codes
`timescale 1ns/1ps
`include "compare_timer_map.svh"

module test_compare_timer_control;
  // clock, reset and register port
  logic       core_clk = 1'b0;
  logic       nrst;
  logic [7:0] regAddr;
  logic [7:0] regWrData;
  logic       regWr;
  logic       regRd;
  logic [7:0] regRdData;
  // prescaler option, pin and outputs
  logic       divOption;
  logic       triggerPin;
  logic       compareMatchIrq;
  logic       pulseOut;
  // tallies of the run
  int         failures;
  int         checks_done;

  // 100 ns period
  always #50 core_clk = ~core_clk;

  compare_timer_control DUT (
    .core_clk(core_clk), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .divOption(divOption),
    .triggerPin(triggerPin), .compareMatchIrq(compareMatchIrq), .pulseOut(pulseOut));

  // far side of the pin
  trigger_pin_source pinSrc (.core_clk(core_clk), .triggerPin(triggerPin));

  // compare and tally; case inequality so unknowns never match
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // one-cycle write; the trailing delay lets its effect land before sampling
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    regAddr   <= a;
    regWrData <= v;
    regWr     <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
    #1;
  endtask

  // one-cycle read; data stands only in the following cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 d = regRdData;
  endtask

  // whole words, low byte then high
  task automatic load_word(input logic [15:0] w);
    wr(`OFS_CMP_LOW, w[7:0]);
    wr(`OFS_CMP_HIGH, w[15:8]);
  endtask

  // cycles until the next interrupt pulse, -1 when none within the limit
  task automatic wait_irq(input int limit, output int n);
    n = -1;
    for (int i = 1; i <= limit; i++) begin
      @(posedge core_clk);
      #1;
      if (compareMatchIrq === 1'b1) begin
        n = i;
        break;
      end
    end
  endtask

  // running flag of the status register
  task automatic status_is(input string what, input logic exp);
    logic [7:0] d;
    rd(`OFS_STATUS, d);
    check(what, d[0], exp);
  endtask

  // move the pin, allow for the synchroniser, then look at the run flag
  task automatic pin_status(input logic lvl, input logic exp);
    pinSrc.set_level(lvl);
    repeat (6) @(posedge core_clk);
    status_is("run after pin edge", exp);
  endtask

  task automatic test_registers();
    logic [7:0] d;
    rd(`OFS_CTRL_PRI, d);
    check("primary after reset", d, `PRI_RESET);
    wr(`OFS_CTRL_SEC, 8'hFF);
    check("flop set", pulseOut, 1'b1);
    rd(`OFS_CTRL_SEC, d);
    check("secondary read", d, 8'h7F);
    wr(`OFS_CTRL_SEC, 8'h40);
    check("flop clear", pulseOut, 1'b0);
    rd(`OFS_CMP_LOW, d);
    check("low byte read", d, 8'h00);
    rd(`OFS_CMP_HIGH, d);
    check("high byte read", d, 8'h00);
    rd(8'h20, d);
    check("unmapped read", d, 8'h00);
    wr(`OFS_CTRL_PRI, 8'h7E);
    rd(`OFS_CTRL_PRI, d);
    check("primary read", d, 8'h7E);
    wr(`OFS_CTRL_PRI, 8'hFE);
    rd(`OFS_CTRL_PRI, d);
    check("soft reset bit", d, 8'h00);
    rd(`OFS_CTRL_SEC, d);
    check("secondary cleared", d, 8'h00);
    $display("test registers done");
  endtask

  task automatic test_timer();
    int n;
    wr(`OFS_CTRL_PRI, 8'h80);
    wr(`OFS_CTRL_SEC, 8'h5A);
    load_word(16'h0100);
    wr(`OFS_CMP_LOW, 8'h09);
    load_word(16'h0003);
    wr(`OFS_CTRL_PRI, 8'h01);
    wait_irq(600, n);
    wait_irq(20, n);
    check("timer period", n[15:0], 16'd8);
    status_is("running", 1'b1);
    wr(`OFS_CTRL_PRI, 8'h00);
    wait_irq(60, n);
    check("no irq when stopped", n[15:0], 16'hFFFF);
    status_is("stopped", 1'b0);
    $display("test timer done");
  endtask

  task automatic test_clocks();
    int n;
    int sh[6] = '{11, 7, 5, 3, 2, 1};
    for (int c = 0; c < 8; c++) begin
      divOption <= (c == 7);
      wr(`OFS_CTRL_PRI, 8'h80);
      wr(`OFS_CTRL_SEC, 8'h40 | 8'((c == 7 ? 5 : c) << 1));
      load_word(16'h0002);
      wr(`OFS_CTRL_PRI, 8'h01);
      wait_irq(c == 6 ? 200 : 7000, n);
      wait_irq(c == 6 ? 10 : 7000, n);
      // code 110 never ticks; the option doubles every period
      if (c == 6) check("unusable code", n[15:0], 16'hFFFF);
      else check("clock period", n[15:0], 16'(3 << (c == 7 ? 2 : sh[c])));
    end
    divOption <= 1'b0;
    $display("test clocks done");
  endtask

  task automatic test_one_shot();
    int n;
    logic [7:0] d;
    wr(`OFS_CTRL_PRI, 8'h80);
    wr(`OFS_CTRL_SEC, 8'h4A);
    load_word(16'h0002);
    wr(`OFS_CTRL_PRI, 8'h11);
    wait_irq(50, n);
    check("one shot irq", 16'(n > 0), 16'd1);
    wait_irq(100, n);
    check("one shot no repeat", n[15:0], 16'hFFFF);
    rd(`OFS_CTRL_PRI, d);
    check("start bit cleared", d, 8'h10);
    status_is("one shot stopped", 1'b0);
    $display("test one shot done");
  endtask

  task automatic test_trigger();
    wr(`OFS_CTRL_PRI, 8'h80);
    wr(`OFS_CTRL_SEC, 8'h0A);
    load_word(16'h0100);
    wr(`OFS_CTRL_PRI, 8'h03);
    pin_status(1'b0, 1'b0);
    pin_status(1'b1, 1'b1);
    pin_status(1'b0, 1'b1);
    pin_status(1'b1, 1'b1);
    pin_status(1'b0, 1'b1);
    wr(`OFS_CTRL_PRI, 8'h00);
    status_is("software stop", 1'b0);
    wr(`OFS_CTRL_PRI, 8'h07);
    pin_status(1'b1, 1'b1);
    pin_status(1'b0, 1'b0);
    wr(`OFS_CTRL_PRI, 8'h00);
    wr(`OFS_CTRL_PRI, 8'h0B);
    pin_status(1'b1, 1'b0);
    pin_status(1'b0, 1'b1);
    wr(`OFS_CTRL_PRI, 8'h00);
    wr(`OFS_CTRL_SEC, 8'h4A);
    wr(`OFS_CTRL_PRI, 8'h03);
    pin_status(1'b1, 1'b0);
    wr(`OFS_CTRL_PRI, 8'h00);
    $display("test trigger done");
  endtask

  task automatic test_pulse();
    int n;
    int tog;
    logic prev;
    for (int r = 0; r < 4; r++) begin
      wr(`OFS_CTRL_PRI, 8'h80);
      wr(`OFS_CTRL_PRI, 8'h20);
      wr(`OFS_CTRL_SEC, 8'h4A | 8'(r << 4));
      load_word(16'h0002);
      // a B word outside pulse mode is dropped, pointer back to A
      if (r == 1) begin
        wr(`OFS_CTRL_PRI, 8'h00);
        load_word(16'h0009);
        wr(`OFS_CTRL_PRI, 8'h20);
        load_word(16'h0002);
      end
      if (r == 2) load_word(16'h0004);
      if (r == 1 || r == 2) load_word(16'h0006);
      wr(`OFS_CTRL_PRI, 8'h21);
      wait_irq(200, n);
      wait_irq(200, n);
      check("pulse period", n[15:0], (r == 1 || r == 2) ? 16'd14 : 16'd6);
      // any window of one whole period holds the same number of toggles
      tog = 0;
      prev = pulseOut;
      repeat (n) begin
        @(posedge core_clk);
        #1;
        if (pulseOut !== prev) tog++;
        prev = pulseOut;
      end
      check("toggles per period", 16'(tog), r == 2 ? 16'd3 : (r == 1 ? 16'd2 : 16'd1));
    end
    // catch the output just after it rises, so the soft reset lands while it is high
    for (int i = 0; i < 20 && pulseOut !== 1'b0; i++) @(posedge core_clk) #1;
    for (int i = 0; i < 20 && pulseOut !== 1'b1; i++) @(posedge core_clk) #1;
    check("output high before reset", pulseOut, 1'b1);
    wr(`OFS_CTRL_PRI, 8'h80);
    check("output after soft reset", pulseOut, 1'b0);
    $display("test pulse done");
  endtask

  // code 111 takes each active pin edge as the count tick
  task automatic test_events();
    int n;
    pinSrc.set_level(1'b0);
    wr(`OFS_CTRL_PRI, 8'h80);
    wr(`OFS_CTRL_SEC, 8'h0E);
    load_word(16'h0002);
    wr(`OFS_CTRL_PRI, 8'h01);
    for (int e = 1; e <= 3; e++) begin
      pinSrc.set_level(1'b1);
      wait_irq(5, n);
      check("event match", 16'(n > 0), 16'(e == 3));
      pinSrc.set_level(1'b0);
    end
    wr(`OFS_CTRL_PRI, 8'h00);
    $display("test events done");
  endtask

  // single exit of the run
  task automatic complete_run();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // watchdog well beyond the longest expected run
  initial begin
    repeat (90000) @(posedge core_clk);
    failures++;
    complete_run();
  end

  // reset, then every scenario in turn
  initial begin
    nrst      = 1'b0;
    regAddr   = 8'h00;
    regWrData = 8'h00;
    regWr     = 1'b0;
    regRd     = 1'b0;
    divOption = 1'b0;
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    test_registers();
    test_timer();
    test_clocks();
    test_one_shot();
    test_trigger();
    test_events();
    test_pulse();
    complete_run();
  end
endmodule
